// ==== common/adc_ctrl_pkg.sv ====
// Constants, register map and types for the converter control block
`default_nettype none
package adc_ctrl_pkg;
    // Widths
    localparam int RES_W = 10;
    localparam int CH_W = 5;
    localparam int NUM_PINS = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int FMT_W = 2;
    localparam int CK_DIV_W = 3;
    localparam int TICK_W = 16;
    localparam int TCNT_W = 5;
    // Register byte addresses
    localparam logic [7:0] OFS_STATUS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CLOCK = 8'h04;
    localparam logic [7:0] OFS_RES_HIGH = 8'h08;
    localparam logic [7:0] OFS_RES_LOW = 8'h0c;
    localparam logic [7:0] OFS_PORT_DATA = 8'h10;
    localparam logic [7:0] OFS_PORT_DIR = 8'h14;
    localparam logic [7:0] OFS_PORT_PINS = 8'h18;
    // Field positions
    localparam int SC_CONT_BIT = 5;
    localparam int SC_IEN_BIT = 6;
    localparam int SC_FLAG_BIT = 7;
    localparam int CK_MODE_LSB = 2;
    localparam int CK_SRC_BIT = 4;
    localparam int CK_DIV_LSB = 5;
    // Channel codes and reset values
    localparam logic [4:0] CH_PIN_LIMIT = 5'h08;
    localparam logic [4:0] CH_REF_HIGH = 5'h1d;
    localparam logic [4:0] CH_REF_LOW = 5'h1e;
    localparam logic [4:0] CH_OFF = 5'h1f;
    localparam logic [4:0] CH_RESET = 5'h1f;
    localparam logic [7:0] CLK_REG_RESET = 8'h00;
    localparam logic [7:0] PORT_RESET = 8'h00;
    // Timing
    localparam int CORE_CLK_PERIOD_NS = 5;
    localparam int ADC_CLK_PERIOD_NS = 1000;
    localparam int ADC_PRE_DIV = ADC_CLK_PERIOD_NS / CORE_CLK_PERIOD_NS;
    localparam int CONV_MIN_CYC = 16;
    localparam int CONV_MAX_CYC = 17;
    // Result formats
    typedef enum logic [1:0] {
        FMT_TRUNC = 2'b00,
        FMT_RIGHT = 2'b01,
        FMT_LEFT = 2'b10,
        FMT_SIGNED = 2'b11
    } fmt_t;
    // Conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_APPROX = 2'b10,
        ST_SETTLE = 2'b11
    } conv_state_t;
endpackage
`default_nettype wire

// ==== logic/conv_sequencer.sv ====
// Successive approximation sequencer timed by converter clock ticks
`default_nettype none
module conv_sequencer
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Control
    input wire logic tick_i,
    input wire logic start_i,
    // Comparator side
    input wire logic comp_i,
    output logic [RES_W-1:0] sar_o,
    // Status
    output logic busy_o,
    output logic done_o
);
    localparam logic [TCNT_W-1:0] LAST_TICK = TCNT_W'(CONV_MAX_CYC - 1);
    localparam logic [3:0] TOP_BIT = 4'(RES_W - 1);

    conv_state_t state_ff;
    logic [TCNT_W-1:0] tcnt_ff;
    logic [3:0] bit_ff;
    logic [RES_W-1:0] sar_ff;
    logic done_ff;
    logic [TCNT_W-1:0] seen_ff;
    logic last_tick;

    assign last_tick = tick_i && (tcnt_ff == LAST_TICK);
    assign sar_o = sar_ff;
    assign busy_o = (state_ff != ST_IDLE);
    assign done_o = done_ff;

    // State walk: sample, ten trials, settle to the last tick
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_ff <= ST_IDLE;
        end else if (start_i) begin
            state_ff <= ST_SAMPLE;
        end else begin
            case (state_ff)
                ST_SAMPLE: if (tick_i) state_ff <= ST_APPROX;
                ST_APPROX: if (tick_i && bit_ff == 4'h0) state_ff <= ST_SETTLE;
                ST_SETTLE: if (last_tick) state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Converter clock ticks since start
    always_ff @(posedge clk_i) begin
        if (srst_i || start_i) begin
            tcnt_ff <= '0;
        end else if (tick_i && busy_o) begin
            tcnt_ff <= tcnt_ff + TCNT_W'(1);
        end
    end

    // Trial register, one bit decided per tick
    always_ff @(posedge clk_i) begin
        if (srst_i || start_i) begin
            sar_ff <= '0;
            bit_ff <= TOP_BIT;
        end else if (tick_i && state_ff == ST_SAMPLE) begin
            sar_ff <= {1'b1, {(RES_W-1){1'b0}}};
        end else if (tick_i && state_ff == ST_APPROX) begin
            sar_ff[bit_ff] <= comp_i;
            if (bit_ff != 4'h0) begin
                sar_ff[bit_ff - 4'h1] <= 1'b1;
                bit_ff <= bit_ff - 4'h1;
            end
        end
    end

    // One-cycle end of conversion
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= !start_i && state_ff == ST_SETTLE && last_tick;
        end
    end

    // Ticks since start for the check below, counted apart from the state walk
    always_ff @(posedge clk_i) begin
        if (srst_i || start_i) begin
            seen_ff <= '0;
        end else if (tick_i && seen_ff != '1) begin
            seen_ff <= seen_ff + TCNT_W'(1);
        end
    end

    chk_conv_ticks: assert property (@(posedge clk_i) disable iff (srst_i)
        done_o |-> (seen_ff >= TCNT_W'(CONV_MIN_CYC)) && (seen_ff <= TCNT_W'(CONV_MAX_CYC)))
        else $error("conversion length out of range");
endmodule
`default_nettype wire

// ==== logic/result_formatter.sv ====
// Lays a 10-bit result out into high and low result bytes
`default_nettype none
module result_formatter
    import adc_ctrl_pkg::*;
(
    // Inputs
    input wire logic [RES_W-1:0] result_i,
    input wire logic [FMT_W-1:0] fmt_i,
    // Outputs
    output logic [BYTE_W-1:0] high_o,
    output logic [BYTE_W-1:0] low_o,
    output logic interlock_o
);
    // Format selection
    always_comb begin
        high_o = '0;
        low_o = '0;
        interlock_o = 1'b1;
        case (fmt_t'(fmt_i))
            FMT_LEFT: begin
                high_o = result_i[9:2];
                low_o = {result_i[1:0], 6'h00};
            end
            FMT_SIGNED: begin
                high_o = {~result_i[9], result_i[8:2]};
                low_o = {result_i[1:0], 6'h00};
            end
            FMT_RIGHT: begin
                high_o = {6'h00, result_i[9:8]};
                low_o = result_i[7:0];
            end
            default: begin
                low_o = result_i[9:2];
                interlock_o = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// ==== logic/adc_conversion_control.sv ====
// Converter control: registers, start logic, pin override, result store
// Contract
// - Ten-bit results come from one converter shared across multiplexed channels.
// - At conversion end the result is stored, then flag or interrupt raised.
// - The selected port pin is forced to input for the converter.
// - Unselected pins stay under ordinary port control as general I/O.
// - Port data and direction writes leave the selected pin untouched.
// - Software reading the selected pin sees zero.
// - Upper reference gives all ones, lower reference all zeros, linear between.
// - Writing the status and control register starts a conversion.
// - A conversion takes 16 to 17 converter clock cycles.
// - Continuous mode overwrites results whether read or not.
// - Continuous mode restarts conversions until its bit is cleared.
// - Flag mode sets the flag each conversion, held until a result read.
// - Single mode performs one conversion per control write, then stops.
// - Two format bits in the clock register choose one of four formats.
// - Left format: eight top bits high, two low bits in low register.
// - Justified formats hold results after a high read until low is read.
// - Right format: two top bits high, eight low bits in low register.
// - Signed format is left format with the top result bit inverted.
// - Truncation puts eight top bits low, drops two, no interlock.
// - Five-bit channel code: pins 0-7, two references, all ones powers off.
// - Interrupt mode: request per conversion, flag reads zero, dropped on read/write.
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`default_nettype none
module adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int PRE_DIV = ADC_PRE_DIV
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic SRST_I,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [DATA_W-1:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // Analog front end
    input wire logic COMP_I,
    output logic [RES_W-1:0] TRIAL_CODE_O,
    output logic [CH_W-1:0] MUX_SEL_O,
    output logic POWER_DOWN_O,
    // Shared port pins
    input wire logic [NUM_PINS-1:0] PIN_IN_I,
    output logic [NUM_PINS-1:0] PIN_OUT_O,
    output logic [NUM_PINS-1:0] PIN_OE_O,
    // Conversion complete interrupt
    output logic IRQ_O
);
    // ==========================================================
    // Declarations
    logic waitreq_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] rd_mux;
    logic req, acc, wr_acc, rd_acc;
    logic hit_sc, hit_clk, hit_high, hit_low, hit_data, hit_dir;
    logic sc_write, res_read;
    logic [CH_W-1:0] ch_ff;
    logic cont_ff, ien_ff, conversion_complete_flag_ff, irq_ff;
    logic [BYTE_W-1:0] clk_reg_ff;
    logic [BYTE_W-1:0] res_high_ff, res_low_ff;
    logic lock_ff, locked;
    logic [NUM_PINS-1:0] port_data_ff, port_dir_ff, pin_out_ff, pin_oe_ff;
    logic [NUM_PINS-1:0] sel_mask;
    logic power_down_ff;
    logic [TICK_W-1:0] tick_cnt_ff, tick_limit;
    logic tick_ff;
    logic conv_start, conv_busy, conv_done;
    logic [RES_W-1:0] conv_result;
    logic [BYTE_W-1:0] fmt_high, fmt_low;
    logic fmt_lock;
    logic [CK_DIV_W-1:0] div_bits;
    logic [CH_W-1:0] new_ch;

    // ==========================================================
    // Bus slave
    // Request decode
    assign req = AVS_READ_I | AVS_WRITE_I;
    assign acc = req & ~waitreq_ff;
    assign wr_acc = acc & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
    assign rd_acc = acc & AVS_READ_I;
    assign hit_sc = (AVS_ADDRESS_I == OFS_STATUS_CTRL);
    assign hit_clk = (AVS_ADDRESS_I == OFS_CLOCK);
    assign hit_high = (AVS_ADDRESS_I == OFS_RES_HIGH);
    assign hit_low = (AVS_ADDRESS_I == OFS_RES_LOW);
    assign hit_data = (AVS_ADDRESS_I == OFS_PORT_DATA);
    assign hit_dir = (AVS_ADDRESS_I == OFS_PORT_DIR);
    assign sc_write = wr_acc & hit_sc;
    assign res_read = rd_acc & (hit_high | hit_low);
    assign new_ch = AVS_WRITEDATA_I[CH_W-1:0];

    // One wait cycle, then a single accept cycle
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            waitreq_ff <= 1'b1;
        end else begin
            waitreq_ff <= !(req && waitreq_ff);
        end
    end

    // Read data mux, unmapped reads return zero
    always_comb begin
        rd_mux = '0;
        case (AVS_ADDRESS_I)
            OFS_STATUS_CTRL: begin
                rd_mux[CH_W-1:0] = ch_ff;
                rd_mux[SC_CONT_BIT] = cont_ff;
                rd_mux[SC_IEN_BIT] = ien_ff;
                rd_mux[SC_FLAG_BIT] = conversion_complete_flag_ff & ~ien_ff;
            end
            OFS_CLOCK: rd_mux[BYTE_W-1:0] = clk_reg_ff;
            OFS_RES_HIGH: rd_mux[BYTE_W-1:0] = res_high_ff;
            OFS_RES_LOW: rd_mux[BYTE_W-1:0] = res_low_ff;
            OFS_PORT_DATA: rd_mux[BYTE_W-1:0] = port_data_ff;
            OFS_PORT_DIR: rd_mux[BYTE_W-1:0] = port_dir_ff;
            OFS_PORT_PINS: rd_mux[BYTE_W-1:0] = PIN_IN_I & ~sel_mask;
            default: rd_mux = '0;
        endcase
    end

    // Read data captured in the wait cycle
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            rdata_ff <= '0;
        end else if (req && waitreq_ff && AVS_READ_I) begin
            rdata_ff <= rd_mux;
        end
    end

    // ==========================================================
    // Control registers
    // Status and control fields
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            ch_ff <= CH_RESET;
            cont_ff <= 1'b0;
            ien_ff <= 1'b0;
        end else if (sc_write) begin
            ch_ff <= new_ch;
            cont_ff <= AVS_WRITEDATA_I[SC_CONT_BIT];
            ien_ff <= AVS_WRITEDATA_I[SC_IEN_BIT];
        end
    end

    // Clock register: divider, source, format
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            clk_reg_ff <= CLK_REG_RESET;
        end else if (wr_acc && hit_clk) begin
            clk_reg_ff <= AVS_WRITEDATA_I[BYTE_W-1:0];
        end
    end

    // ==========================================================
    // Converter clock and sequencing
    // Tick period from divider and source select
    assign div_bits = clk_reg_ff[CK_DIV_LSB +: CK_DIV_W];
    always_comb begin
        if (clk_reg_ff[CK_SRC_BIT]) begin
            tick_limit = TICK_W'(1) << div_bits;
        end else begin
            tick_limit = TICK_W'(PRE_DIV) << div_bits;
        end
    end

    // Tick generator
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff >= tick_limit - TICK_W'(1)) begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
            tick_ff <= 1'b0;
        end
    end

    // Start on control write, or again at end in continuous mode
    always_comb begin
        if (sc_write) begin
            conv_start = (new_ch != CH_OFF);
        end else begin
            conv_start = conv_done && cont_ff && (ch_ff != CH_OFF);
        end
    end

    conv_sequencer u_seq (
        .clk_i(CORE_CLK_I),
        .srst_i(SRST_I),
        .tick_i(tick_ff),
        .start_i(conv_start),
        .comp_i(COMP_I),
        .sar_o(conv_result),
        .busy_o(conv_busy),
        .done_o(conv_done)
    );

    result_formatter u_fmt (
        .result_i(conv_result),
        .fmt_i(clk_reg_ff[CK_MODE_LSB +: FMT_W]),
        .high_o(fmt_high),
        .low_o(fmt_low),
        .interlock_o(fmt_lock)
    );

    // ==========================================================
    // Result store and interlock
    assign locked = lock_ff & fmt_lock;

    // New result written unless interlocked
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            res_high_ff <= '0;
            res_low_ff <= '0;
        end else if (conv_done && !locked) begin
            res_high_ff <= fmt_high;
            res_low_ff <= fmt_low;
        end
    end

    // High read locks, low read unlocks
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            lock_ff <= 1'b0;
        end else if (rd_acc && hit_low) begin
            lock_ff <= 1'b0;
        end else if (rd_acc && hit_high && fmt_lock) begin
            lock_ff <= 1'b1;
        end
    end

    // ==========================================================
    // Completion flag and interrupt
    // Flag: set wins over a same-cycle read
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            conversion_complete_flag_ff <= 1'b0;
        end else if (conv_done && !ien_ff) begin
            conversion_complete_flag_ff <= 1'b1;
        end else if (res_read) begin
            conversion_complete_flag_ff <= 1'b0;
        end
    end

    // Request: set wins over read or control write
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            irq_ff <= 1'b0;
        end else if (conv_done && ien_ff) begin
            irq_ff <= 1'b1;
        end else if (res_read || sc_write) begin
            irq_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Port pin sharing
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            assign sel_mask[gi] = (ch_ff == CH_W'(gi));
            // Port data and direction, selected bit frozen
            always_ff @(posedge CORE_CLK_I) begin
                if (SRST_I) begin
                    port_data_ff[gi] <= PORT_RESET[gi];
                    port_dir_ff[gi] <= PORT_RESET[gi];
                end else if (!sel_mask[gi]) begin
                    if (wr_acc && hit_data) port_data_ff[gi] <= AVS_WRITEDATA_I[gi];
                    if (wr_acc && hit_dir) port_dir_ff[gi] <= AVS_WRITEDATA_I[gi];
                end
            end
            // Pin drivers, selected pin released as input
            always_ff @(posedge CORE_CLK_I) begin
                if (SRST_I) begin
                    pin_out_ff[gi] <= 1'b0;
                    pin_oe_ff[gi] <= 1'b0;
                end else begin
                    pin_out_ff[gi] <= port_data_ff[gi];
                    pin_oe_ff[gi] <= port_dir_ff[gi] & ~sel_mask[gi];
                end
            end
        end
    endgenerate

    // Converter power-down on the all-ones code
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            power_down_ff <= 1'b1;
        end else begin
            power_down_ff <= (ch_ff == CH_OFF);
        end
    end

    // ==========================================================
    // Outputs
    assign AVS_READDATA_O = rdata_ff;
    assign AVS_WAITREQUEST_O = waitreq_ff;
    assign TRIAL_CODE_O = conv_result;
    assign MUX_SEL_O = ch_ff;
    assign POWER_DOWN_O = power_down_ff;
    assign PIN_OUT_O = pin_out_ff;
    assign PIN_OE_O = pin_oe_ff;
    assign IRQ_O = irq_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SRST_I);

    chk_start_on_write: assert property (
        sc_write && new_ch != CH_OFF |=> conv_busy)
        else $error("no conversion after control write");
    chk_single_stops: assert property (
        conv_done && !cont_ff && !sc_write |=> !conv_busy)
        else $error("single mode kept converting");
    chk_cont_restart: assert property (
        conv_done && cont_ff && ch_ff != CH_OFF && !sc_write |=> conv_busy)
        else $error("continuous mode did not restart");
    chk_flag_set_hold: assert property (
        conv_done && !ien_ff |=> conversion_complete_flag_ff ##1 (conversion_complete_flag_ff || $past(res_read)))
        else $error("completion flag not set or dropped early");
    chk_irq_raise: assert property (
        conv_done && ien_ff && !sc_write |=> IRQ_O
        && (AVS_ADDRESS_I != OFS_STATUS_CTRL || !rd_mux[SC_FLAG_BIT]))
        else $error("interrupt missing or flag visible");
    chk_irq_drop: assert property (
        (res_read || sc_write) && !conv_done |=> !IRQ_O)
        else $error("interrupt not dropped");
    chk_sel_pin_input: assert property (
        $stable(ch_ff) && ch_ff < CH_PIN_LIMIT |-> !PIN_OE_O[ch_ff[2:0]])
        else $error("selected pin still driven");
    chk_pin_read_zero: assert property (
        req && waitreq_ff && AVS_READ_I && AVS_ADDRESS_I == OFS_PORT_PINS
        |=> (AVS_READDATA_O[BYTE_W-1:0] & $past(sel_mask)) == 8'h00)
        else $error("selected pin read not zero");
    chk_lock_hold: assert property (
        conv_done && locked |=> $stable(res_high_ff) && $stable(res_low_ff))
        else $error("result stored while interlocked");
    chk_left_layout: assert property (
        conv_done && !locked && fmt_t'(clk_reg_ff[CK_MODE_LSB +: FMT_W]) == FMT_LEFT
        |=> res_high_ff == $past(conv_result[9:2]))
        else $error("left format high byte wrong");
    chk_right_layout: assert property (
        conv_done && !locked && fmt_t'(clk_reg_ff[CK_MODE_LSB +: FMT_W]) == FMT_RIGHT
        |=> res_low_ff == $past(conv_result[7:0]))
        else $error("right format low byte wrong");

    cov_continuous: cover property (conv_done && cont_ff ##[1:1000] conv_done);
    cov_interlock: cover property (conv_done && locked);
    cov_irq_read: cover property (IRQ_O ##1 res_read);
endmodule
`default_nettype wire

// ==== tb/front_model.sv ====
// Behavioural analog front end: comparator on the selected input
`default_nettype none
module front_model
    import adc_ctrl_pkg::*;
(
    // Converter side
    input wire logic [RES_W-1:0] trial_i,
    input wire logic [CH_W-1:0] mux_i,
    input wire logic pd_i,
    // Analog levels of the eight pins
    input wire logic [NUM_PINS-1:0][RES_W-1:0] level_i,
    output logic comp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [RES_W-1:0] vin;
    // Input picked by the mux; references sit at the code ends
    always_comb begin
        if (mux_i == CH_REF_HIGH) begin
            vin = 10'h3ff;
        end else if (mux_i == CH_REF_LOW) begin
            vin = 10'h000;
        end else begin
            vin = level_i[mux_i[2:0]];
        end
    end
    // Powered down: comparator output is meaningless, so it wanders
    assign comp_o = pd_i ? ~trial_i[0] : (vin >= trial_i);
endmodule
`default_nettype wire

// ==== tb/tb_adc_conversion_control.sv ====
// Self-checking bench for the converter control block
`default_nettype none
module tb_adc_conversion_control
    import adc_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, rd = 0, wr = 0, comp, pd, irq, wreq;
    logic [7:0] adr = 8'h00, pin_in, pin_out, pin_oe, ext = 8'h3c;
    logic [31:0] wd = 0, rdat, q;
    logic [7:0][9:0] lv = '0;
    logic [9:0] trial;
    logic [4:0] mux;
    logic [2:0] c;
    logic [15:0] x;
    int failures = 0, comparisons = 0, i;
    integer seed = 32'h98bb;
    // Clock and pin wire levels
    always #2.5 clk = ~clk;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
    adc_conversion_control #(.PRE_DIV(4)) dut (.CORE_CLK_I(clk), .SRST_I(srst),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
        .AVS_BYTEENABLE_I(4'h1), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
        .COMP_I(comp), .TRIAL_CODE_O(trial), .MUX_SEL_O(mux), .POWER_DOWN_O(pd),
        .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out), .PIN_OE_O(pin_oe), .IRQ_O(irq));
    front_model fm (.trial_i(trial), .mux_i(mux), .pd_i(pd), .level_i(lv), .comp_o(comp));
    // Expected high and low bytes for a result
    function automatic logic [15:0] lay(input logic [9:0] v, input logic [1:0] f);
        case (f)
            FMT_TRUNC: lay = {8'h00, v[9:2]};
            FMT_RIGHT: lay = {6'h00, v};
            FMT_LEFT: lay = {v, 6'h00};
            default: lay = {~v[9], v[8:0], 6'h00};
        endcase
    endfunction
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        adr <= a;
        wr <= w;
        rd <= ~w;
        wd <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n == 50) failures++;
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic start(input logic [4:0] ch, input logic [1:0] f, input logic [1:0] md);
        bus(1'b1, OFS_CLOCK, {1'b0, 2'($random(seed)), 1'($random(seed)), f, 2'b00});
        bus(1'b1, OFS_STATUS_CTRL, {1'b0, md, ch});
    endtask
    task automatic wait_done();
        for (int k = 0; k < 250; k++) begin
            bus(1'b0, OFS_STATUS_CTRL, 8'h00);
            if (q[7] === 1'b1 || irq === 1'b1) break;
        end
    endtask
    task automatic res(input logic [9:0] v, input logic [1:0] f);
        x = lay(v, f);
        bus(1'b0, OFS_RES_HIGH, 8'h00);
        chk("result high", 32'(x[15:8]), q);
        bus(1'b0, OFS_RES_LOW, 8'h00);
        chk("result low", 32'(x[7:0]), q);
    endtask
    task automatic summarize();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #200000;
        failures++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        bus(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk("status reset", 32'h1f, q);
        bus(1'b0, 8'h40, 8'h00);
        chk("unmapped", 32'h0, q);
        // Every format on random pins, with both end codes first
        for (i = 0; i < 8; i++) begin
            c = 3'($random(seed));
            lv[c] <= (i < 2) ? {10{i[0]}} : 10'($random(seed));
            start({2'b00, c}, 2'(i), 2'b00);
            wait_done();
            chk("flag", 32'h1, 32'(q[7]));
            res(lv[c], 2'(i));
            bus(1'b0, OFS_STATUS_CTRL, 8'h00);
            chk("flag clear", 32'h0, 32'(q[7]));
        end
        for (i = 0; i < 2; i++) begin
            start(i ? CH_REF_LOW : CH_REF_HIGH, FMT_RIGHT, 2'b00);
            wait_done();
            res(i ? 10'h000 : 10'h3ff, FMT_RIGHT);
        end
        // Pin override while pin 3 converts
        start(5'h03, FMT_RIGHT, 2'b00);
        bus(1'b1, OFS_PORT_DIR, 8'hff);
        bus(1'b1, OFS_PORT_DATA, 8'ha5);
        @(posedge clk); // Pin drivers lag the port registers by one cycle
        chk("pin enable", 32'hf7, 32'(pin_oe));
        chk("pin data", 32'ha5 & 32'hf7, 32'(pin_out & 8'hf7));
        bus(1'b0, OFS_PORT_PINS, 8'h00);
        chk("pin read", 32'ha5 & 32'hf7, q);
        wait_done();
        res(lv[3], FMT_RIGHT);
        // High read locks out the next result until low is read
        lv[2] <= 10'h155;
        start(5'h02, FMT_LEFT, 2'b00);
        wait_done();
        bus(1'b0, OFS_RES_HIGH, 8'h00);
        chk("high", 32'h55, q);
        lv[2] <= 10'h2aa;
        start(5'h02, FMT_LEFT, 2'b00);
        wait_done();
        bus(1'b0, OFS_RES_LOW, 8'h00);
        chk("held low", 32'h40, q);
        start(5'h02, FMT_LEFT, 2'b00);
        wait_done();
        res(10'h2aa, FMT_LEFT);
        // Truncation has no lock
        start(5'h02, FMT_TRUNC, 2'b00);
        wait_done();
        bus(1'b0, OFS_RES_HIGH, 8'h00);
        lv[2] <= 10'h0f0;
        start(5'h02, FMT_TRUNC, 2'b00);
        wait_done();
        res(10'h0f0, FMT_TRUNC);
        // Interrupt mode, dropped by read and by control write
        start(5'h05, FMT_RIGHT, 2'b10);
        wait_done();
        chk("irq", 32'h1, 32'(irq));
        chk("flag masked", 32'h0, 32'(q[7]));
        bus(1'b0, OFS_RES_LOW, 8'h00);
        chk("irq read drop", 32'h0, 32'(irq));
        start(5'h05, FMT_RIGHT, 2'b10);
        wait_done();
        bus(1'b1, OFS_STATUS_CTRL, 8'h5f);
        chk("irq write drop", 32'h0, 32'(irq));
        @(posedge clk); // Power-down flop follows the channel field one cycle later
        chk("power down", 32'h1, 32'(pd));
        // Continuous mode keeps converting and overwrites
        start(5'h01, FMT_RIGHT, 2'b01);
        wait_done();
        res(lv[1], FMT_RIGHT);
        lv[1] <= 10'h321;
        wait_done();
        bus(1'b0, OFS_RES_LOW, 8'h00);
        wait_done();
        res(10'h321, FMT_RIGHT);
        start(5'h01, FMT_RIGHT, 2'b00);
        wait_done();
        res(10'h321, FMT_RIGHT);
        repeat (600) @(posedge clk);
        bus(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk("single stops", 32'h0, 32'(q[7]));
        // Reset in mid conversion aborts it and returns the status and control fields to reset
        start(5'h04, FMT_RIGHT, 2'b11);
        repeat (3) @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        bus(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk("status after reset", 32'h1f, q);
        repeat (150) @(posedge clk);
        bus(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk("no flag after reset", 32'h1f, q);
        chk("no irq after reset", 32'h0, 32'(irq));
        summarize();
    end
endmodule
`default_nettype wire
